// ===== logic/pmcm_pkg.sv
/*
  Package for the power mode clock manager: register offsets, field
  positions, reset values, divider codes and timing counts.
  Assumes a single 125 MHz clock and a synchronous active-low reset.
*/
package pmcm_pkg;
  // register offsets on the plain register port
  localparam logic [1:0] PMCM_ADDR_POWER_CONTROL_REG   = 2'h0;  // power_control_reg
  localparam logic [1:0] PMCM_ADDR_PMR    = 2'h1;  // power_mode_reg
  localparam logic [1:0] PMCM_ADDR_STATUS = 2'h2;  // live state, read only
  localparam logic [1:0] PMCM_ADDR_WDOG   = 2'h3;  // watchdog control

  // power_control_reg fields
  localparam int PMCM_POWER_CONTROL_REG_IDLE = 0;
  localparam int PMCM_POWER_CONTROL_REG_PD   = 1;
  // power_mode_reg fields
  localparam int PMCM_PMR_SWB   = 5;
  localparam int PMCM_PMR_CD_LO = 6;
  localparam int PMCM_PMR_CD_HI = 7;
  // watchdog control fields
  localparam int PMCM_WD_RUN    = 0;
  localparam int PMCM_WD_RSTEN  = 1;
  localparam int PMCM_WD_CLEAR  = 2;

  localparam logic [7:0] PMCM_POWER_CONTROL_REG_RST = 8'h00;
  localparam logic [7:0] PMCM_PMR_RST  = 8'h40;

  // divider codes
  localparam logic [1:0] PMCM_CD_RSVD = 2'h0;
  localparam logic [1:0] PMCM_CD_4    = 2'h1;
  localparam logic [1:0] PMCM_CD_64   = 2'h2;
  localparam logic [1:0] PMCM_CD_1024 = 2'h3;
  localparam logic [9:0] PMCM_DIV4_LAST    = 10'h003;
  localparam logic [9:0] PMCM_DIV64_LAST   = 10'h03F;
  localparam logic [9:0] PMCM_DIV1024_LAST = 10'h3FF;

  // timing
  localparam int CLK_PERIOD_NS       = 8;
  localparam int EXT_RST_MIN_CLKS    = 8;   // two machine cycles at /4
  localparam int WDOG_RST_DELAY_CLKS = 512;
  localparam int INSTR_DELAY_MCYC    = 1;   // rate change latency in machine cycles
  localparam logic [3:0] PMCM_RST_MIN  = 4'(EXT_RST_MIN_CLKS);
  localparam logic [9:0] PMCM_WD_DELAY = 10'(WDOG_RST_DELAY_CLKS - 1);
  localparam logic [15:0] PMCM_WD_TIMEOUT_DFLT = 16'hFFFF;

  typedef enum logic [1:0] {PMCM_RUN, PMCM_IDLE, PMCM_PDOWN} pmcm_mode_e;
endpackage

// ===== logic/pmcm_top.sv
/*
  Power mode clock manager: idle, power-down and economy modes, the
  machine-cycle divider with switchback, wake-up and reset exits, pin
  state control in the low-power modes, and the watchdog timeout path.
  Assumes the core, peripherals and interrupt controller consume the
  enable pulses and pin controls produced here on the same clock.
*/
// Design decisions made here: the address-and-strobe port and the placing of the registers.
// How it works
// - idle bit enters idle after current instruction
// - idle gates core clock, peripherals keep running
// - idle: strobes high, ports hold levels
// - external memory: port0 floats, port2 address/data
// - enabled interrupt clears idle, resumes execution
// - reset pin needs eight clocks high
// - watchdog runs in idle, resets 512 later
// - reset exit from idle skips next instruction
// - divider field: 4, 64, 1024; 00 reserved
// - new rate applies one instruction later
// - economy slows peripherals; idle keeps them /4
// - switchback returns to divide-by-4 immediately
// - start-bit edge or transmit write triggers switchback
// - divider writes ignored during serial activity while switchback is enabled
// - every reset source restores divide-by-4
// - power-down bit stops all clocks
// - power-down: strobes low, port0 floats with external memory, other ports show registers
// - reset pin ends power-down, restart 0000h
// - enabled low external interrupt wakes power-down
`timescale 1ns/10ps
module pmcm_top (
  input  wire logic        clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [1:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // core side
  input  wire logic        instr_done,
  input  wire logic        irq_active,
  input  wire logic        irq_ack_ext,
  input  wire logic        ext_mem_mode,
  // pins from outside the clock domain
  input  wire logic        ext_reset_pin,
  input  wire logic        ext_int_pin_n,
  input  wire logic        ser_rx_pin,
  // wake-up qualifiers, serial status and power-on reset
  input  wire logic        ext_int_enabled,
  input  wire logic        global_interrupt_enable,
  input  wire logic        ser_rx_enable,
  input  wire logic        ser_tx_write,
  input  wire logic        ser_busy,
  input  wire logic        por_reset,
  // outputs
  output logic             core_clk_en,
  output logic             periph_clk_en,
  output logic             osc_run,
  output logic             sys_reset,
  output logic             skip_next_instr,
  output logic             wdog_irq,
  output logic             ale_level,
  output logic             program_read_strobe,
  output logic             pin_hold,
  output logic             port0_float,
  output logic             port2_addr_sel
);
  import pmcm_pkg::*;

  pmcm_mode_e  mode_reg;
  logic [7:0]  power_control_reg_reg;
  logic [1:0]  cd_reg;          // software-visible divider field
  logic        swb_reg;
  logic [1:0]  cd_act_reg;      // divider in force
  logic [1:0]  cd_pend_reg;
  logic        pend_reg;
  logic [9:0]  div_cnt_reg;
  logic [1:0]  per_cnt_reg;
  logic [2:0]  rst_sync_reg;
  logic [2:0]  int_sync_reg;
  logic [2:0]  rx_sync_reg;
  logic        rst_pin_reg;
  logic        int_low_reg;
  logic        rx_level_reg;
  logic [3:0]  rst_cnt_reg;
  logic        ext_rst_reg;
  logic [2:0]  wd_ctl_reg;
  logic [15:0] wd_cnt_reg;
  logic        wd_flag_reg;
  logic [9:0]  wd_dly_reg;
  logic        wd_rst_reg;
  logic        was_idle_reg;

  // synchronisers: a change counts once stages two and three agree
  always_ff @(posedge clk) begin
    rst_sync_reg <= {rst_sync_reg[1:0], ext_reset_pin};
    int_sync_reg <= {int_sync_reg[1:0], ext_int_pin_n};
    rx_sync_reg  <= {rx_sync_reg[1:0], ser_rx_pin};
  end

  wire rst_agree = rst_sync_reg[1] == rst_sync_reg[2];
  wire int_agree = int_sync_reg[1] == int_sync_reg[2];
  wire rx_agree  = rx_sync_reg[1] == rx_sync_reg[2];

  // filtered pin levels
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rst_pin_reg  <= 1'b0;
      int_low_reg  <= 1'b0;
      rx_level_reg <= 1'b1;
    end else begin
      if (rst_agree) rst_pin_reg <= rst_sync_reg[2];
      if (int_agree) int_low_reg <= ~int_sync_reg[2];
      if (rx_agree)  rx_level_reg <= rx_sync_reg[2];
    end
  end

  // external reset must stand eight clocks before it counts
  wire rst_cnt_full = rst_cnt_reg == PMCM_RST_MIN;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rst_cnt_reg <= '0;
      ext_rst_reg <= 1'b0;
    end else begin
      if (!rst_pin_reg)
        rst_cnt_reg <= '0;
      else if (!rst_cnt_full)
        rst_cnt_reg <= rst_cnt_reg + 4'h1;
      ext_rst_reg <= rst_pin_reg && rst_cnt_full;
    end
  end

  // any reset source; the watchdog one only while clocks run
  wire any_reset = ext_rst_reg || wd_rst_reg || por_reset;

  // register decode
  wire wr_power_control_reg = reg_wr && reg_addr == PMCM_ADDR_POWER_CONTROL_REG;
  wire wr_pmr  = reg_wr && reg_addr == PMCM_ADDR_PMR;
  wire wr_wd   = reg_wr && reg_addr == PMCM_ADDR_WDOG;
  wire [1:0] cd_wdata = {reg_wdata[PMCM_PMR_CD_HI], reg_wdata[PMCM_PMR_CD_LO]};

  // switchback triggers: start-bit falling edge, transmit write, external irq
  wire rx_fall   = rx_agree && rx_level_reg && !rx_sync_reg[2];
  wire swb_trig  = swb_reg && ((ser_rx_enable && rx_fall) || ser_tx_write
                               || irq_ack_ext);
  // divider writes blocked while serial is busy under switchback
  wire cd_locked = swb_reg && ser_busy;
  wire cd_accept = wr_pmr && !cd_locked && cd_wdata != PMCM_CD_RSVD;

  // machine-cycle divider; the end of each cycle is the enable pulse
  wire [9:0] div_last = (cd_act_reg == PMCM_CD_64)   ? PMCM_DIV64_LAST :
                        (cd_act_reg == PMCM_CD_1024) ? PMCM_DIV1024_LAST :
                                                       PMCM_DIV4_LAST;
  wire mcyc_tick = div_cnt_reg >= div_last;
  wire per_tick  = per_cnt_reg == PMCM_DIV4_LAST[1:0];
  wire clocks_on = mode_reg != PMCM_PDOWN;

  // wake from power-down: enabled external interrupt pin held low
  wire pd_wake = int_low_reg && ext_int_enabled && global_interrupt_enable;

  // mode machine
  always_ff @(posedge clk) begin
    if (!rst_n || any_reset) begin
      mode_reg <= PMCM_RUN;
    end else begin
      case (mode_reg)
        PMCM_RUN: begin
          // bits take effect once the setting instruction completes
          if (instr_done && power_control_reg_reg[PMCM_POWER_CONTROL_REG_PD])
            mode_reg <= PMCM_PDOWN;
          else if (instr_done && power_control_reg_reg[PMCM_POWER_CONTROL_REG_IDLE])
            mode_reg <= PMCM_IDLE;
        end
        PMCM_IDLE: begin
          if (irq_active) mode_reg <= PMCM_RUN;
        end
        PMCM_PDOWN: begin
          if (pd_wake) mode_reg <= PMCM_RUN;
        end
        default: mode_reg <= PMCM_RUN;
      endcase
    end
  end

  // power control bits; hardware clears them on wake
  always_ff @(posedge clk) begin
    if (!rst_n || any_reset) begin
      power_control_reg_reg <= PMCM_POWER_CONTROL_REG_RST;
    end else if (wr_power_control_reg) begin
      power_control_reg_reg <= reg_wdata;
    end else if (mode_reg == PMCM_IDLE && irq_active) begin
      power_control_reg_reg[PMCM_POWER_CONTROL_REG_IDLE] <= 1'b0;
    end else if (mode_reg == PMCM_PDOWN && pd_wake) begin
      power_control_reg_reg[PMCM_POWER_CONTROL_REG_PD] <= 1'b0;
    end
  end

  // divider field, switchback enable and the delayed rate change
  always_ff @(posedge clk) begin
    if (!rst_n || any_reset) begin
      cd_reg      <= PMCM_CD_4;
      cd_act_reg  <= PMCM_CD_4;
      cd_pend_reg <= PMCM_CD_4;
      pend_reg    <= 1'b0;
      swb_reg     <= PMCM_PMR_RST[PMCM_PMR_SWB];
    end else begin
      if (wr_pmr) swb_reg <= reg_wdata[PMCM_PMR_SWB];
      if (swb_trig) begin
        // switchback wins over a pending economy request
        cd_reg     <= PMCM_CD_4;
        cd_act_reg <= PMCM_CD_4;
        pend_reg   <= 1'b0;
      end else if (cd_accept) begin
        cd_reg      <= cd_wdata;
        cd_pend_reg <= cd_wdata;
        pend_reg    <= 1'b1;
      end else if (pend_reg && instr_done) begin
        // one instruction later; the core's done pulse trails the cycle end,
        // so waiting for both at once would never switch the rate
        cd_act_reg <= cd_pend_reg;
        pend_reg   <= 1'b0;
      end
    end
  end

  // machine-cycle and peripheral dividers
  always_ff @(posedge clk) begin
    if (!rst_n || mcyc_tick || swb_trig || !clocks_on)
      div_cnt_reg <= '0;
    else
      div_cnt_reg <= div_cnt_reg + 10'h001;
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !clocks_on)
      per_cnt_reg <= '0;
    else
      per_cnt_reg <= per_cnt_reg + 2'h1;
  end

  // watchdog control: run, reset enable, clear strobe
  always_ff @(posedge clk) begin
    if (!rst_n || por_reset)
      wd_ctl_reg <= '0;
    else if (wr_wd)
      wd_ctl_reg <= reg_wdata[2:0];
    else
      wd_ctl_reg[PMCM_WD_CLEAR] <= 1'b0;
  end

  // watchdog ticks at the peripheral rate; stopped in power-down
  wire wd_tick = (mode_reg == PMCM_IDLE) ? per_tick : mcyc_tick;
  wire wd_clr  = wd_ctl_reg[PMCM_WD_CLEAR] || !wd_ctl_reg[PMCM_WD_RUN];
  always_ff @(posedge clk) begin
    if (!rst_n || wd_clr || any_reset) begin
      wd_cnt_reg  <= '0;
      wd_flag_reg <= 1'b0;
      wd_dly_reg  <= '0;
      wd_rst_reg  <= 1'b0;
    end else if (clocks_on) begin
      if (wd_tick && !wd_flag_reg) begin
        wd_cnt_reg <= wd_cnt_reg + 16'h0001;
        if (wd_cnt_reg == PMCM_WD_TIMEOUT_DFLT) wd_flag_reg <= 1'b1;
      end
      if (wd_flag_reg) begin
        // reset follows the timeout by 512 clocks unless cleared
        if (wd_dly_reg == PMCM_WD_DELAY)
          wd_rst_reg <= wd_ctl_reg[PMCM_WD_RSTEN];
        else
          wd_dly_reg <= wd_dly_reg + 10'h001;
      end
    end
  end

  // remember a reset that arrived during idle
  always_ff @(posedge clk) begin
    if (!rst_n)
      was_idle_reg <= 1'b0;
    else
      was_idle_reg <= any_reset && mode_reg == PMCM_IDLE;
  end

  // outputs, all registered
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      core_clk_en         <= 1'b0;
      periph_clk_en       <= 1'b0;
      osc_run             <= 1'b1;
      sys_reset           <= 1'b1;
      skip_next_instr     <= 1'b0;
      wdog_irq            <= 1'b0;
      ale_level           <= 1'b1;
      program_read_strobe <= 1'b1;
      pin_hold            <= 1'b0;
      port0_float         <= 1'b0;
      port2_addr_sel      <= 1'b0;
    end else begin
      core_clk_en   <= mode_reg == PMCM_RUN && mcyc_tick;
      periph_clk_en <= (mode_reg == PMCM_IDLE) ? per_tick
                     : (mode_reg == PMCM_RUN && mcyc_tick);
      osc_run       <= clocks_on || pd_wake || rst_pin_reg;
      sys_reset     <= any_reset;
      skip_next_instr <= was_idle_reg;
      wdog_irq      <= wd_flag_reg;
      // strobes high in idle, low in power-down
      ale_level           <= mode_reg != PMCM_PDOWN;
      program_read_strobe <= mode_reg != PMCM_PDOWN;
      pin_hold            <= mode_reg == PMCM_IDLE;
      port0_float         <= mode_reg != PMCM_RUN && ext_mem_mode;
      port2_addr_sel      <= mode_reg == PMCM_IDLE && ext_mem_mode;
    end
  end

  // register read mux, data valid the cycle after the strobe
  wire [7:0] pmr_view = {cd_reg[1], cd_reg[0], swb_reg, 5'h00};
  wire [7:0] stat_view = {4'h0, pend_reg, wd_flag_reg, mode_reg};
  wire [7:0] rd_mux = (reg_addr == PMCM_ADDR_POWER_CONTROL_REG) ? power_control_reg_reg :
                      (reg_addr == PMCM_ADDR_PMR)  ? pmr_view :
                      (reg_addr == PMCM_ADDR_STATUS) ? stat_view :
                      {5'h00, wd_ctl_reg};
  always_ff @(posedge clk) begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rd_mux;
    else
      reg_rdata <= 8'h00;
  end
endmodule

// ===== testbench/pmcm_chk_sva.sv
/*
  Checker for the power mode clock manager, bound to its top module.
  Assumes one clock with rst_n as a synchronous active-low reset.
*/
`timescale 1ns/10ps
module pmcm_chk (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       irq_active,
  input wire logic       ext_reset_pin,
  input wire logic       ext_int_pin_n,
  input wire logic       ext_int_enabled,
  input wire logic       global_interrupt_enable,
  input wire logic       ext_mem_mode,
  input wire logic       por_reset,
  input wire logic       core_clk_en,
  input wire logic       periph_clk_en,
  input wire logic       osc_run,
  input wire logic       sys_reset,
  input wire logic       ale_level,
  input wire logic       program_read_strobe,
  input wire logic       pin_hold,
  input wire logic       port0_float,
  input wire logic       port2_addr_sel
);
  // all checks share the one clock and its reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_rdata_quiet; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data not idle");
  property p_mcyc_min; core_clk_en |=> !core_clk_en [*3]; endproperty
  a_mcyc_min: assert property (p_mcyc_min) else $error("machine cycle too short");
  property p_idle_core; pin_hold |-> !core_clk_en; endproperty
  a_idle_core: assert property (p_idle_core) else $error("core clocked in idle");
  property p_idle_pins; pin_hold |-> ale_level && program_read_strobe; endproperty
  a_idle_pins: assert property (p_idle_pins) else $error("idle strobes not high");
  property p_idle_per; pin_hold && periph_clk_en |=> !periph_clk_en [*3]; endproperty
  a_idle_per: assert property (p_idle_per) else $error("idle peripheral rate");
  property p_p2; port2_addr_sel |-> pin_hold && ext_mem_mode; endproperty
  a_p2: assert property (p_p2) else $error("port2 address outside idle");
  // the oscillator restarts before the mode leaves power-down, so judge by the strobes
  property p_p0; port0_float |-> ext_mem_mode && (pin_hold || !ale_level); endproperty
  a_p0: assert property (p_p0) else $error("port0 float misplaced");
  property p_pd_pins;
    !osc_run |-> !ale_level && !program_read_strobe && !core_clk_en && !periph_clk_en;
  endproperty
  a_pd_pins: assert property (p_pd_pins) else $error("power-down not quiet");
  property p_idle_wake; pin_hold && irq_active |-> ##[1:4] !pin_hold; endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle not left");
  property p_pd_wake;
    !osc_run && !ext_int_pin_n && ext_int_enabled && global_interrupt_enable |-> ##[1:8] osc_run;
  endproperty
  a_pd_wake: assert property (p_pd_wake) else $error("power-down not woken");
  property p_ext_rst; ext_reset_pin [*8] ##1 ext_reset_pin [*6] |-> ##[0:4] sys_reset; endproperty
  a_ext_rst: assert property (p_ext_rst) else $error("pin reset missed");
  property p_por; por_reset |-> ##[1:3] sys_reset; endproperty
  a_por: assert property (p_por) else $error("power-on reset missed");
endmodule
bind pmcm_top pmcm_chk u_chk (.*);

// ===== testbench/pmcm_core_model.sv
/*
  Far-side model: the core retiring one instruction per machine cycle,
  and a serial line that sends a start bit on request.
  Assumes the bench clock and reset of the manager.
*/
`timescale 1ns/10ps
module pmcm_core_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic core_clk_en,
  input  wire logic rx_go,
  output wire logic instr_done,
  output wire logic ser_rx_pin
);
  logic [4:0] rx_cnt_reg;
  // every machine cycle ends an instruction, so the setting one completes
  assign instr_done = core_clk_en;
  // start bit low for 16 clocks, line idles high between frames
  assign ser_rx_pin = (rx_cnt_reg == 5'h00);
  always_ff @(posedge clk) begin
    if (!rst_n) rx_cnt_reg <= 5'h00;
    else if (rx_go) rx_cnt_reg <= 5'h10;
    else if (rx_cnt_reg != 5'h00) rx_cnt_reg <= rx_cnt_reg - 5'h01;
  end
endmodule

// ===== testbench/tb_top.sv
/*
  Self-checking bench for the power mode clock manager.
  Assumes the core model retires an instruction each machine cycle.
*/
`timescale 1ns/10ps
module tb_top;
  import pmcm_pkg::*;
  logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, irq_active = 0, irq_ack_ext = 0;
  logic ext_mem_mode = 1, ext_reset_pin = 0, ext_int_pin_n = 1, ext_int_enabled = 0;
  logic global_interrupt_enable = 0, ser_rx_enable = 1, ser_tx_write = 0, ser_busy = 0;
  logic por_reset = 0, rx_go = 0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00, d;
  logic [15:0] p;
  wire logic [7:0] reg_rdata;
  wire logic instr_done, ser_rx_pin, core_clk_en, periph_clk_en, osc_run, sys_reset;
  wire logic skip_next_instr, wdog_irq, ale_level, program_read_strobe, pin_hold;
  wire logic port0_float, port2_addr_sel;
  int errors = 0, n_compared = 0, k;
  pmcm_top dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .instr_done(instr_done),
    .irq_active(irq_active), .irq_ack_ext(irq_ack_ext), .ext_mem_mode(ext_mem_mode),
    .ext_reset_pin(ext_reset_pin), .ext_int_pin_n(ext_int_pin_n), .ser_rx_pin(ser_rx_pin),
    .ext_int_enabled(ext_int_enabled), .global_interrupt_enable(global_interrupt_enable),
    .ser_rx_enable(ser_rx_enable), .ser_tx_write(ser_tx_write), .ser_busy(ser_busy),
    .por_reset(por_reset), .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en),
    .osc_run(osc_run), .sys_reset(sys_reset), .skip_next_instr(skip_next_instr),
    .wdog_irq(wdog_irq), .ale_level(ale_level), .program_read_strobe(program_read_strobe),
    .pin_hold(pin_hold), .port0_float(port0_float), .port2_addr_sel(port2_addr_sel));
  pmcm_core_model u_core (.clk(clk), .rst_n(rst_n), .core_clk_en(core_clk_en),
    .rx_go(rx_go), .instr_done(instr_done), .ser_rx_pin(ser_rx_pin));
  always #4 clk = ~clk;
  task report_and_stop;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task guard(input int i);
    if (i >= 3000) begin errors++; report_and_stop(); end
  endtask
  task wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk); reg_addr <= a; reg_wdata <= v; reg_wr <= 1;
    @(posedge clk); reg_wr <= 0;
  endtask
  task rd(input logic [1:0] a);
    @(posedge clk); reg_addr <= a; reg_rd <= 1;
    @(posedge clk); reg_rd <= 0; #1 d = reg_rdata;
  endtask
  task tick(input int n); repeat (n) @(posedge clk); endtask
  // length of the last of three intervals between enable pulses
  task per(input logic sel);
    for (int j = 0; j < 3; j++) begin
      p = 0;
      do begin @(posedge clk); #1 p++; end
      while ((sel ? periph_clk_en : core_clk_en) !== 1'b1 && p < 3000);
      guard(p);
    end
  endtask
  // wait until a chosen output reaches a level: 0 pin_hold 1 osc_run 2 sys_reset 3 skip
  task wt(input int s, input logic v);
    int i;
    for (i = 0; i < 3000; i++) begin
      if ((s == 0 ? pin_hold : s == 1 ? osc_run : s == 2 ? sys_reset : skip_next_instr) === v)
        break;
      @(posedge clk); #1;
    end
    guard(i);
  endtask
  task t_reset_vals;
    rd(PMCM_ADDR_PMR); chk(d, 16'h0040);
    rd(PMCM_ADDR_POWER_CONTROL_REG); chk(d, 16'h0000);
    rd(PMCM_ADDR_STATUS); chk(d & 8'h03, 16'h0000);
    per(0); chk(p, 16'h0004);
    // watchdog armed; its long timeout stays far beyond this run
    wr(PMCM_ADDR_WDOG, 8'h03); rd(PMCM_ADDR_WDOG); chk(d, 16'h0003);
    chk(wdog_irq, 16'h0000);
  endtask
  task t_economy;
    wr(PMCM_ADDR_PMR, 8'h80); per(0); chk(p, 16'h0040);
    wr(PMCM_ADDR_PMR, 8'h00); per(0); chk(p, 16'h0040);
    wr(PMCM_ADDR_PMR, 8'h40); per(0); chk(p, 16'h0004);
    wr(PMCM_ADDR_PMR, 8'hC0); per(0); chk(p, 16'h0400);
    wr(PMCM_ADDR_PMR, 8'h40); per(0); chk(p, 16'h0004);
  endtask
  task t_switchback;
    for (k = 0; k < 3; k++) begin
      wr(PMCM_ADDR_PMR, 8'hA0); per(0); chk(p, 16'h0040);
      @(posedge clk);
      if (k == 0) ser_tx_write <= 1; else if (k == 1) rx_go <= 1; else irq_ack_ext <= 1;
      @(posedge clk); ser_tx_write <= 0; rx_go <= 0; irq_ack_ext <= 0;
      per(0); chk(p, 16'h0004);
    end
    @(posedge clk); ser_busy <= 1;
    wr(PMCM_ADDR_PMR, 8'hA0); per(0); chk(p, 16'h0004);
    rd(PMCM_ADDR_PMR); chk(d, 16'h0060);
    @(posedge clk); ser_busy <= 0;
    wr(PMCM_ADDR_PMR, 8'h40);
  endtask
  task t_idle;
    wr(PMCM_ADDR_POWER_CONTROL_REG, 8'h01); wt(0, 1);
    chk({ale_level, program_read_strobe, port0_float, port2_addr_sel}, 16'h000F);
    rd(PMCM_ADDR_STATUS); chk(d & 8'h03, 16'h0001);
    per(1); chk(p, 16'h0004);
    @(posedge clk); irq_active <= 1; wt(0, 0);
    @(posedge clk); irq_active <= 0;
    rd(PMCM_ADDR_POWER_CONTROL_REG); chk(d & 8'h01, 16'h0000);
  endtask
  task pin_reset;
    @(posedge clk); ext_reset_pin <= 1; tick(16); ext_reset_pin <= 0;
  endtask
  task t_pdown;
    wr(PMCM_ADDR_POWER_CONTROL_REG, 8'h02); wt(1, 0);
    chk({ale_level, program_read_strobe, port0_float, port2_addr_sel}, 16'h0002);
    @(posedge clk); ext_int_enabled <= 1; global_interrupt_enable <= 1; ext_int_pin_n <= 0;
    wt(1, 1);
    @(posedge clk); ext_int_pin_n <= 1; ext_int_enabled <= 0;
    wr(PMCM_ADDR_POWER_CONTROL_REG, 8'h02); wt(1, 0);
    pin_reset(); wt(2, 0); chk(osc_run, 16'h0001);
    rd(PMCM_ADDR_POWER_CONTROL_REG); chk(d, 16'h0000);
  endtask
  task t_reset_exits;
    wr(PMCM_ADDR_PMR, 8'h80); wr(PMCM_ADDR_POWER_CONTROL_REG, 8'h01); wt(0, 1);
    // the skip pulse stands one cycle while the pin is still high, so watch during it
    @(posedge clk); ext_reset_pin <= 1;
    wt(3, 1); chk(skip_next_instr, 16'h0001);
    tick(4); ext_reset_pin <= 0;
    wt(2, 0); rd(PMCM_ADDR_PMR); chk(d, 16'h0040);
    wr(PMCM_ADDR_PMR, 8'h80);
    @(posedge clk); por_reset <= 1; tick(4); por_reset <= 0;
    wt(2, 0); per(0); chk(p, 16'h0004);
  endtask
  initial begin
    tick(20); rst_n <= 1;
    t_reset_vals(); t_economy(); t_switchback(); t_idle(); t_pdown(); t_reset_exits();
    report_and_stop();
  end
endmodule
